// ===== tdcrc_readout.v
// Result queues, post-processing, resets, timer and flags of the converter
`timescale 1ns/1ps
`default_nettype none
`include "tdcrc_consts.vh"

// Operation
// - One queue per channel, one push per clock
// - Pipeline subtracts selected start from stop
// - Bus 28 bits, 16 when word written
// - Output-enable pin low keeps drivers on
// - Empty and fill flags per queue, high
// - Fill flag at shared threshold count
// - Quiet mode processes only on trigger
// - First result about 900 ns after trigger
// - Start offset scaled by multiplier plus one
// - Result in bits 22..0, rest zero
// - Queue heads read at offsets 8, 9
// - Power-up reset clears config and queues, then blanks inputs
// - Full reset keeps config, clears queues
// - Partial reset keeps config and queues
// - Inputs blanked 40 ns or 75 ns, rounded up to 2 or 3 clocks
// - Interval timer, period up to 8191
// - Timer started by start, stop, either
// - Interrupt is OR of unmasked events
// - Error is OR of unmasked events
// - Test inputs replace measurement inputs
// - Start offset added to each interval
module tdcrc_readout #(
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset (rst is the inverted power-up reset pin)
	input wire clk,
	input wire rst,
	// Register port
	input wire [3:0] addr,
	input wire [27:0] wdata,
	input wire wr,
	input wire rd,
	output reg [27:0] rdata,
	// Data bus driver control
	input wire output_enable_pin_n,
	output reg bus_oe_n,
	// Processing trigger pin
	input wire proc_trigger_pin,
	// Raw hits from the measurement core
	input wire hit_valid,
	input wire hit_is_start,
	input wire hit_chan,
	input wire [22:0] hit_time,
	// Raw hits from the test inputs
	input wire test_valid,
	input wire test_is_start,
	input wire test_chan,
	input wire [22:0] test_time,
	// Core status events
	input wire [7:0] hit_queue_full,
	input wire hit_queues_empty,
	input wire pll_unlocked,
	// Flags
	output wire [1:0] queue_empty_flag,
	output wire [1:0] queue_fill_level_flag,
	output wire irq_flag,
	output wire err_flag
);
	// ****************************************************************
	// Derived timing
	// ****************************************************************
	// Typical figure, rounded up to whole cycles
	localparam LAT_CYC = (`TDCRC_FIRST_RESULT_NS + `TDCRC_CLK_PERIOD_NS - 1)
		/ `TDCRC_CLK_PERIOD_NS;
	localparam BLK_FULL = (`TDCRC_BLANK_FULL_NS + `TDCRC_CLK_PERIOD_NS - 1)
		/ `TDCRC_CLK_PERIOD_NS;
	localparam BLK_PART = (`TDCRC_BLANK_PART_NS + `TDCRC_CLK_PERIOD_NS - 1)
		/ `TDCRC_CLK_PERIOD_NS;
	// Processing states, one-hot
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_PROC = 3'b100;

	// Offset in base bins times three, times multiplier plus one
	function [22:0] scale_offset;
		input [17:0] off;
		input [4:0] mult;
		input mode_en;
		reg [29:0] prod;
		begin
			prod = {12'h000, off} * 30'd3;
			if (mode_en) begin
				prod = prod * ({25'h000_0000, mult} + 30'd1);
			end
			scale_offset = prod[22:0];
		end
	endfunction

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	reg [27:0] cfg3_reg; // Multiplier and test select
	reg [27:0] cfg4_reg; // Mode, quiet, timer sources
	reg [27:0] cfg5_reg; // Start offset, pin reset enables
	reg [27:0] cfg6_reg; // Fill threshold
	reg [27:0] cfg7_reg; // Timer period
	reg [27:0] errmsk_reg; // Error event mask
	reg [27:0] irqmsk_reg; // Interrupt event mask
	reg [27:0] buscfg_reg; // Bus width
	reg half_reg; // 16-bit mode word pointer
	reg [15:0] wlow_reg; // Low half of a split write
	wire bus16 = buscfg_reg[`TDCRC_BUS16_BIT];
	wire quiet = cfg4_reg[`TDCRC_QUIET_BIT];
	wire [4:0] mult = cfg3_reg[`TDCRC_MULT_LSB +: 5];
	wire [12:0] tmr_period = cfg7_reg[`TDCRC_TMR_LSB +: 13];
	// A write counts once both halves arrived in 16-bit mode
	wire wr_eff = wr & (~bus16 | half_reg);
	wire [27:0] wd_eff = bus16 ? {wdata[11:0], wlow_reg} : wdata;
	wire wr4 = wr_eff & (addr == `TDCRC_ADR_CFG4);

	// Config registers only fall to power-up reset
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg3_reg <= `TDCRC_CFG_RESET;
			cfg4_reg <= `TDCRC_CFG_RESET;
			cfg5_reg <= `TDCRC_CFG_RESET;
			cfg6_reg <= `TDCRC_CFG_RESET;
			cfg7_reg <= `TDCRC_CFG_RESET;
			errmsk_reg <= `TDCRC_CFG_RESET;
			irqmsk_reg <= `TDCRC_CFG_RESET;
			buscfg_reg <= `TDCRC_CFG_RESET;
			half_reg <= 1'b0;
			wlow_reg <= 16'h0000;
		end else begin
			// Pointer toggles on every strobe while narrow
			if (bus16 & (wr | rd)) begin
				half_reg <= ~half_reg;
			end else if (~bus16) begin
				half_reg <= 1'b0;
			end
			if (bus16 & wr & ~half_reg) begin
				wlow_reg <= wdata[15:0];
			end
			if (wr_eff) begin
				case (addr)
				`TDCRC_ADR_CFG3: cfg3_reg <= wd_eff;
				// Strobe bits self-clear; only mode bits stay
				`TDCRC_ADR_CFG4: begin
					cfg4_reg <= wd_eff & ~28'h1C0_0000;
				end
				`TDCRC_ADR_CFG5: cfg5_reg <= wd_eff;
				`TDCRC_ADR_CFG6: cfg6_reg <= wd_eff;
				`TDCRC_ADR_CFG7: cfg7_reg <= wd_eff;
				`TDCRC_ADR_ERRMSK: errmsk_reg <= wd_eff;
				`TDCRC_ADR_IRQMSK: irqmsk_reg <= wd_eff;
				`TDCRC_ADR_BUSCFG: buscfg_reg <= wd_eff;
				default: begin
				end
				endcase
			end
		end
	end

	// ****************************************************************
	// Pin synchronisers and reset sources
	// ****************************************************************
	reg [1:0] trig_sync_reg; // Trigger pin, stage 0 feeds stage 1 only
	reg trig_last_reg; // Previous synchronised trigger
	reg [1:0] oe_sync_reg; // Output-enable pin synchroniser
	reg oe_last_reg; // Previous synchronised enable
	wire trig_rise = trig_sync_reg[1] & ~trig_last_reg;
	wire oe_fall = ~oe_sync_reg[1] & oe_last_reg;

	// Two flops each; edges detected after the second only
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			trig_sync_reg <= 2'b00;
			trig_last_reg <= 1'b0;
			oe_sync_reg <= 2'b11;
			oe_last_reg <= 1'b1;
		end else begin
			trig_sync_reg <= {trig_sync_reg[0], proc_trigger_pin};
			trig_last_reg <= trig_sync_reg[1];
			oe_sync_reg <= {oe_sync_reg[0], output_enable_pin_n};
			oe_last_reg <= oe_sync_reg[1];
		end
	end

	// Pin triggers depend on quiet mode and enables
	wire full_rst = (wr4 & wd_eff[`TDCRC_FULL_RST_BIT]) |
		(~quiet & trig_rise & cfg5_reg[`TDCRC_FULL_ON_TRIG_BIT]) |
		(quiet & oe_fall & cfg5_reg[`TDCRC_FULL_ON_OE_BIT]);
	wire part_rst = (wr4 & wd_eff[`TDCRC_PART_RST_BIT]) |
		(~quiet & trig_rise & cfg5_reg[`TDCRC_PART_ON_TRIG_BIT]) |
		(quiet & oe_fall & cfg5_reg[`TDCRC_PART_ON_OE_BIT]);
	wire any_rst = full_rst | part_rst;
	// Quiet processing trigger: pin edge or software bit
	wire proc_trig = quiet & (trig_rise |
		(wr4 & wd_eff[`TDCRC_PROC_TRIG_BIT]));

	// ****************************************************************
	// Input blanking and hit selection
	// ****************************************************************
	reg [1:0] blank_reg; // Cycles left with inputs closed

	// Full reset wins the shorter window only if alone
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			blank_reg <= BLK_FULL[1:0];
		end else if (part_rst) begin
			blank_reg <= BLK_PART[1:0];
		end else if (full_rst) begin
			blank_reg <= BLK_FULL[1:0];
		end else if (blank_reg != 2'd0) begin
			blank_reg <= blank_reg - 2'd1;
		end
	end

	// Test inputs take the place of the core hits
	wire tsel = cfg3_reg[`TDCRC_TEST_SEL_BIT];
	wire h_valid = (tsel ? test_valid : hit_valid) &
		(blank_reg == 2'd0);
	wire h_start = tsel ? test_is_start : hit_is_start;
	wire h_chan = tsel ? test_chan : hit_chan;
	wire [22:0] h_time = tsel ? test_time : hit_time;

	// ****************************************************************
	// Hit holding and post-processing pipeline
	// ****************************************************************
	reg start_ok_reg; // A start has been seen
	reg [22:0] start_t_reg; // Latest start time stamp
	reg [1:0] stop_ok_reg; // One stop held per channel
	reg [22:0] stop_t_reg [0:1]; // Held stop times
	reg [2:0] st_reg; // Processing state
	reg [5:0] lat_reg; // Latency count before first result
	reg ch_reg; // Channel under processing
	reg s1_valid_reg; // Stage 1 holds a difference
	reg s1_ch_reg; // Stage 1 channel
	reg [22:0] s1_val_reg; // Stop minus start
	reg push_reg; // Stage 2 pushes this cycle
	reg push_ch_reg; // Stage 2 channel
	reg [22:0] push_val_reg; // Final result
	wire [22:0] offset_bins = scale_offset(
		cfg5_reg[17:0], mult, cfg4_reg[`TDCRC_MODE_EN_BIT]);

	// Holds the start until a reset, and stops until processing takes them
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			start_ok_reg <= 1'b0;
			start_t_reg <= 23'h00_0000;
			stop_ok_reg <= 2'b00;
			stop_t_reg[0] <= 23'h00_0000;
			stop_t_reg[1] <= 23'h00_0000;
		end else if (any_rst) begin
			start_ok_reg <= 1'b0;
			stop_ok_reg <= 2'b00;
		end else begin
			if (st_reg == ST_PROC) begin
				stop_ok_reg[ch_reg] <= 1'b0;
			end
			if (h_valid & h_start) begin
				start_ok_reg <= 1'b1;
				start_t_reg <= h_time;
			end else if (h_valid & ~stop_ok_reg[h_chan]) begin
				stop_ok_reg[h_chan] <= 1'b1;
				stop_t_reg[h_chan] <= h_time;
			end
		end
	end

	// Sequencer: wait after a quiet trigger, then one channel a cycle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= ST_IDLE;
			lat_reg <= 6'd0;
			ch_reg <= 1'b0;
		end else if (any_rst) begin
			st_reg <= ST_IDLE;
			lat_reg <= 6'd0;
			ch_reg <= 1'b0;
		end else begin
			case (st_reg)
			ST_IDLE: begin
				ch_reg <= 1'b0;
				if (proc_trig) begin
					st_reg <= ST_WAIT;
					lat_reg <= LAT_CYC[5:0] - 6'd3;
				end else if (~quiet & start_ok_reg &
					(stop_ok_reg != 2'b00)) begin
					st_reg <= ST_PROC;
				end
			end
			ST_WAIT: begin
				// Pipeline depth makes up the remaining cycles
				if (lat_reg == 6'd0) begin
					st_reg <= ST_PROC;
				end else begin
					lat_reg <= lat_reg - 6'd1;
				end
			end
			ST_PROC: begin
				ch_reg <= ~ch_reg;
				if (ch_reg) begin
					st_reg <= ST_IDLE;
				end
			end
			default: st_reg <= ST_IDLE;
			endcase
		end
	end

	// Two stages: select and subtract, then add offset and trim
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_valid_reg <= 1'b0;
			s1_ch_reg <= 1'b0;
			s1_val_reg <= 23'h00_0000;
			push_reg <= 1'b0;
			push_ch_reg <= 1'b0;
			push_val_reg <= 23'h00_0000;
		end else if (any_rst) begin
			s1_valid_reg <= 1'b0;
			push_reg <= 1'b0;
		end else begin
			s1_valid_reg <= (st_reg == ST_PROC) & start_ok_reg &
				stop_ok_reg[ch_reg];
			s1_ch_reg <= ch_reg;
			s1_val_reg <= stop_t_reg[ch_reg] - start_t_reg;
			push_reg <= s1_valid_reg;
			push_ch_reg <= s1_ch_reg;
			push_val_reg <= s1_val_reg + offset_bins;
		end
	end

	// ****************************************************************
	// Interface queues
	// ****************************************************************
	reg [22:0] qmem [0:2*DEPTH-1]; // Both queues, channel in top index
	reg [AW-1:0] wp_reg [0:1]; // Write pointers
	reg [AW-1:0] rp_reg [0:1]; // Read pointers
	reg [AW:0] cnt_reg [0:1]; // Fill counts
	wire [1:0] q_full;
	wire [1:0] pop;
	wire rd_q = rd & ((addr == `TDCRC_ADR_QUEUE0) |
		(addr == `TDCRC_ADR_QUEUE1));
	integer i;

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_flag
			assign q_full[g] = (cnt_reg[g] == DEPTH[AW:0]);
			assign queue_empty_flag[g] = (cnt_reg[g] == {(AW+1){1'b0}});
			// Compared straight from the count, may spike during reads
			assign queue_fill_level_flag[g] =
				({{(27-AW){1'b0}}, cnt_reg[g]} >= cfg6_reg) &
				(cfg6_reg != 28'h000_0000);
			// Second half pops in 16-bit mode; empty reads are ignored
			assign pop[g] = rd_q & (addr[0] == g) &
				(~bus16 | half_reg) & ~queue_empty_flag[g];
		end
	endgenerate

	// Full reset empties queues, partial reset leaves them
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 2; i = i + 1) begin
				wp_reg[i] <= {AW{1'b0}};
				rp_reg[i] <= {AW{1'b0}};
				cnt_reg[i] <= {(AW+1){1'b0}};
			end
		end else if (full_rst) begin
			for (i = 0; i < 2; i = i + 1) begin
				wp_reg[i] <= {AW{1'b0}};
				rp_reg[i] <= {AW{1'b0}};
				cnt_reg[i] <= {(AW+1){1'b0}};
			end
		end else begin
			for (i = 0; i < 2; i = i + 1) begin
				// Results meeting a full queue are dropped
				if (push_reg & (push_ch_reg == i) & ~q_full[i]) begin
					qmem[{i[0], wp_reg[i]}] <= push_val_reg;
					wp_reg[i] <= wp_reg[i] + {{(AW-1){1'b0}}, 1'b1};
				end
				if (pop[i]) begin
					rp_reg[i] <= rp_reg[i] + {{(AW-1){1'b0}}, 1'b1};
				end
				if ((push_reg & (push_ch_reg == i) & ~q_full[i]) &
					~pop[i]) begin
					cnt_reg[i] <= cnt_reg[i] + {{AW{1'b0}}, 1'b1};
				end else if (pop[i] & ~(push_reg &
					(push_ch_reg == i) & ~q_full[i])) begin
					cnt_reg[i] <= cnt_reg[i] - {{AW{1'b0}}, 1'b1};
				end
			end
		end
	end

	// ****************************************************************
	// Interval timer and flags
	// ****************************************************************
	reg [12:0] tmr_reg; // Remaining periods
	reg tmr_run_reg; // Timer counting
	reg tmr_done_reg; // Sticky expiry
	wire tmr_go = h_valid & ((h_start & cfg4_reg[`TDCRC_TMR_ON_START_BIT]) |
		(~h_start & cfg4_reg[`TDCRC_TMR_ON_STOP_BIT]));

	// Counts clock periods; expiry stays until a reset
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tmr_reg <= 13'h0000;
			tmr_run_reg <= 1'b0;
			tmr_done_reg <= 1'b0;
		end else if (any_rst) begin
			tmr_run_reg <= 1'b0;
			tmr_done_reg <= 1'b0;
		end else if (tmr_go & ~tmr_run_reg & (tmr_period != 13'h0000)) begin
			tmr_reg <= tmr_period - 13'h0001;
			tmr_run_reg <= 1'b1;
		end else if (tmr_run_reg) begin
			if (tmr_reg == 13'h0000) begin
				tmr_run_reg <= 1'b0;
				tmr_done_reg <= 1'b1;
			end else begin
				tmr_reg <= tmr_reg - 13'h0001;
			end
		end
	end

	wire [12:0] irq_ev = {tmr_done_reg, hit_queues_empty, pll_unlocked,
		q_full, hit_queue_full};
	wire [10:0] err_ev = {pll_unlocked, q_full, hit_queue_full};
	assign irq_flag = |(irq_ev & irqmsk_reg[`TDCRC_IRQ_LSB +: 13]);
	assign err_flag = |(err_ev & errmsk_reg[`TDCRC_ERR_LSB +: 11]);

	// ****************************************************************
	// Read data and bus driver control
	// ****************************************************************
	reg [27:0] word; // Full word at the read address

	always @* begin
		case (addr)
		`TDCRC_ADR_CFG3: word = cfg3_reg;
		`TDCRC_ADR_CFG4: word = cfg4_reg;
		`TDCRC_ADR_CFG5: word = cfg5_reg;
		`TDCRC_ADR_CFG6: word = cfg6_reg;
		`TDCRC_ADR_CFG7: word = cfg7_reg;
		`TDCRC_ADR_QUEUE0: word = {5'h00, qmem[{1'b0, rp_reg[0]}]};
		`TDCRC_ADR_QUEUE1: word = {5'h00, qmem[{1'b1, rp_reg[1]}]};
		`TDCRC_ADR_STATUS: word = {18'h0_0000, tmr_done_reg,
			tmr_run_reg, irq_flag, err_flag, q_full,
			queue_fill_level_flag, queue_empty_flag};
		`TDCRC_ADR_ERRMSK: word = errmsk_reg;
		`TDCRC_ADR_IRQMSK: word = irqmsk_reg;
		`TDCRC_ADR_BUSCFG: word = buscfg_reg;
		default: word = 28'h000_0000;
		endcase
	end

	// Read data for one cycle; drivers on while pin low
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 28'h000_0000;
			bus_oe_n <= 1'b1;
		end else begin
			bus_oe_n <= ~(rd | ~output_enable_pin_n);
			if (rd & bus16) begin
				rdata <= half_reg ? {16'h0000, word[27:16]} :
					{12'h000, word[15:0]};
			end else if (rd) begin
				rdata <= word;
			end else begin
				rdata <= 28'h000_0000;
			end
		end
	end

endmodule // tdcrc_readout
`default_nettype wire

// ===== tdcrc_consts.vh
// Constants for the converter result readout and control block
`ifndef TDCRC_CONSTS_VH
`define TDCRC_CONSTS_VH
// ****************************************************************
// Register word offsets
// ****************************************************************
`define TDCRC_ADR_CFG3 4'h3
`define TDCRC_ADR_CFG4 4'h4
`define TDCRC_ADR_CFG5 4'h5
`define TDCRC_ADR_CFG6 4'h6
`define TDCRC_ADR_CFG7 4'h7
`define TDCRC_ADR_QUEUE0 4'h8
`define TDCRC_ADR_QUEUE1 4'h9
`define TDCRC_ADR_STATUS 4'hA
`define TDCRC_ADR_ERRMSK 4'hB
`define TDCRC_ADR_IRQMSK 4'hC
`define TDCRC_ADR_BUSCFG 4'hE
// ****************************************************************
// Field positions
// ****************************************************************
`define TDCRC_MULT_LSB 0
`define TDCRC_TEST_SEL_BIT 24
`define TDCRC_TMR_ON_START_BIT 8
`define TDCRC_MODE_EN_BIT 9
`define TDCRC_TMR_ON_STOP_BIT 10
`define TDCRC_FULL_RST_BIT 22
`define TDCRC_PART_RST_BIT 23
`define TDCRC_PROC_TRIG_BIT 24
`define TDCRC_QUIET_BIT 26
`define TDCRC_FULL_ON_TRIG_BIT 21
`define TDCRC_FULL_ON_OE_BIT 22
`define TDCRC_PART_ON_TRIG_BIT 23
`define TDCRC_PART_ON_OE_BIT 24
`define TDCRC_TMR_LSB 13
`define TDCRC_IRQ_LSB 13
`define TDCRC_ERR_LSB 16
`define TDCRC_BUS16_BIT 4
// ****************************************************************
// Reset values and timing
// ****************************************************************
`define TDCRC_CFG_RESET 28'h000_0000
`define TDCRC_BUS16_VALUE 28'h000_0010
`define TDCRC_CLK_PERIOD_NS 25
`define TDCRC_FIRST_RESULT_NS 900
`define TDCRC_BLANK_FULL_NS 40
`define TDCRC_BLANK_PART_NS 75
`define TDCRC_MAX_RATE_MHZ 40
`endif

// ===== tdcrc_readout_monitor.sv
// Port checker for the converter readout block, with its bind
`timescale 1ns/1ps
`default_nettype none
module tdcrc_readout_chk #(
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic rd,
	input wire logic [27:0] rdata,
	// Bus drivers
	input wire logic output_enable_pin_n,
	input wire logic bus_oe_n,
	// Events and flags
	input wire logic [7:0] hit_queue_full,
	input wire logic pll_unlocked,
	input wire logic [1:0] queue_empty_flag,
	input wire logic [1:0] queue_fill_level_flag,
	input wire logic err_flag
);
	// One domain, so one clock and one reset for all
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ****************************************************************
	// Read data and drivers
	// ****************************************************************
	property p_rd_idle; !rd |=> rdata == 28'h000_0000; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside a read");
	property p_unused;
		rd && (addr == 4'h8 || addr == 4'h9) |=> rdata[27:23] == 5'h00;
	endproperty
	a_unused: assert property (p_unused)
		else $error("unused result bits set");
	property p_oe_pin; !output_enable_pin_n |=> !bus_oe_n; endproperty
	a_oe_pin: assert property (p_oe_pin)
		else $error("drivers off while pin held low");
	property p_oe_rd; rd |=> !bus_oe_n; endproperty
	a_oe_rd: assert property (p_oe_rd)
		else $error("drivers off in read data cycle");
	property p_oe_off; output_enable_pin_n && !rd |=> bus_oe_n; endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("drivers on without cause");
	// ****************************************************************
	// Flags
	// ****************************************************************
	// A fill flag on an empty queue would let the host read garbage
	property p_fill0; queue_empty_flag[0] |-> !queue_fill_level_flag[0];
	endproperty
	a_fill0: assert property (p_fill0)
		else $error("fill flag on empty queue 0");
	property p_fill1; queue_empty_flag[1] |-> !queue_fill_level_flag[1];
	endproperty
	a_fill1: assert property (p_fill1)
		else $error("fill flag on empty queue 1");
	property p_err_calm;
		hit_queue_full == 8'h00 && !pll_unlocked && queue_empty_flag == 2'b11
			|-> !err_flag;
	endproperty
	a_err_calm: assert property (p_err_calm)
		else $error("error flag without any event");
	// Inputs are blanked just after reset, so nothing can arrive yet
	property p_blank; $fell(rst) |-> queue_empty_flag == 2'b11 [*3];
	endproperty
	a_blank: assert property (p_blank)
		else $error("result pushed during blanking");
endmodule // tdcrc_readout_chk
bind tdcrc_readout tdcrc_readout_chk #(.DEPTH(DEPTH), .AW(AW)) u_chk (
	.clk(clk),
	.rst(rst),
	.addr(addr),
	.rd(rd),
	.rdata(rdata),
	.output_enable_pin_n(output_enable_pin_n),
	.bus_oe_n(bus_oe_n),
	.hit_queue_full(hit_queue_full),
	.pll_unlocked(pll_unlocked),
	.queue_empty_flag(queue_empty_flag),
	.queue_fill_level_flag(queue_fill_level_flag),
	.err_flag(err_flag)
);
`default_nettype wire

// ===== tdcrc_hit_model.sv
// Behavioural model of the measurement core hit source
`timescale 1ns/1ps
`default_nettype none
module tdcrc_hit_model (
	// Clock and command
	input wire logic clk,
	input wire logic go,
	input wire logic [22:0] base,
	input wire logic [22:0] d0,
	input wire logic [22:0] d1,
	// Hit port
	output logic v,
	output logic st,
	output logic ch,
	output logic [22:0] tm,
	output logic busy
);
	logic [2:0] s = 3'h0; // Step of the shot
	assign busy = s != 3'h0;
	initial begin
		v = 1'b0;
		st = 1'b0;
		ch = 1'b0;
		tm = 23'h00_0000;
	end
	// Start, then one stop per channel, an idle cycle apart
	always @(posedge clk) begin
		v <= 1'b0;
		tm <= ~tm; // Stale time must never look valid
		if (busy || go)
			s <= s == 3'h5 ? 3'h0 : s + 3'h1;
		if (s[0]) begin
			v <= 1'b1;
			st <= s == 3'h1;
			ch <= s == 3'h5;
			tm <= s == 3'h1 ? base : base + (s == 3'h3 ? d0 : d1);
		end
	end
endmodule // tdcrc_hit_model
`default_nettype wire

// ===== tdcrc_readout_tb.sv
// Self-checking testbench of the converter readout block
`timescale 1ns/1ps
`default_nettype none
module tdcrc_readout_tb;
	localparam logic [27:0] MODE = 28'h000_0200; // Multiplier in use
	localparam logic [27:0] QUIET = 28'h400_0000;
	localparam logic [27:0] PTRIG = 28'h100_0000;
	localparam logic [27:0] FULL = 28'h040_0000;
	localparam logic [27:0] PART = 28'h080_0000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [27:0] wdata = 28'h000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic oen_n = 1'b1;
	logic trig = 1'b0;
	logic [7:0] hqf = 8'h00;
	logic hqe = 1'b0;
	logic pll = 1'b0;
	logic go_c = 1'b0;
	logic go_t = 1'b0;
	logic [22:0] base = 23'h00_0064;
	logic [22:0] d0, d1, da[0:2], db[0:2];
	logic [27:0] rdata, r, r2;
	logic bus_oe_n, hv, hs, hc, tv, ts, tc, bc, bt, irq, err;
	logic [22:0] ht, tt;
	logic [1:0] qe, qf;
	logic [17:0] off;
	int errors = 0;
	int compares = 0;
	int seed = 32'ha5de;
	int cyc = 0;
	int k;
	always #12.5 clk = ~clk;
	tdcrc_readout #(.DEPTH(16), .AW(4)) dut (.clk(clk), .rst(rst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.output_enable_pin_n(oen_n), .bus_oe_n(bus_oe_n),
		.proc_trigger_pin(trig), .hit_valid(hv), .hit_is_start(hs),
		.hit_chan(hc), .hit_time(ht), .test_valid(tv), .test_is_start(ts),
		.test_chan(tc), .test_time(tt), .hit_queue_full(hqf),
		.hit_queues_empty(hqe), .pll_unlocked(pll),
		.queue_empty_flag(qe), .queue_fill_level_flag(qf),
		.irq_flag(irq), .err_flag(err));
	tdcrc_hit_model u_core (.clk(clk), .go(go_c), .base(base), .d0(d0),
		.d1(d1), .v(hv), .st(hs), .ch(hc), .tm(ht), .busy(bc));
	tdcrc_hit_model u_test (.clk(clk), .go(go_t), .base(base), .d0(d0),
		.d1(d1), .v(tv), .st(ts), .ch(tc), .tm(tt), .busy(bt));
	// Offset times three times multiplier plus one, which is 32
	function logic [27:0] expv(input logic [22:0] d);
		expv = {5'h00, d + 23'(off) * 23'h00_0060};
	endfunction
	task chk(input string n, input logic [27:0] e, input logic [27:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task wreg(input logic [3:0] a, input logic [27:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rreg(input logic [3:0] a, output logic [27:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// One start and a stop on each channel; model takes six cycles
	task shot(input logic t);
		d0 = 23'($random(seed)) & 23'h00_ffff;
		d1 = 23'($random(seed)) & 23'h00_ffff;
		@(posedge clk);
		go_c <= !t;
		go_t <= t;
		@(posedge clk);
		go_c <= 1'b0;
		go_t <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	// Bounded wait for both queues to hold data
	task waitq;
		for (int i = 0; i < 100 && qe !== 2'b00; i++) @(posedge clk);
		chk("queues filled", 28'h000_0000, 28'(qe));
	endtask
	task pair;
		rreg(4'h8, r);
		chk("queue 0", expv(d0), r);
		rreg(4'h9, r);
		chk("queue 1", expv(d1), r);
	endtask
	task pulse_trig;
		@(posedge clk);
		trig <= 1'b1;
		repeat (2) @(posedge clk);
		trig <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	task summarize;
		$display("counts: %0d compares, %0d errors", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Hang guard, far above the several hundred cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			summarize;
		end
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		#1 chk("empty", 28'h000_0003, 28'(qe));
		chk("fill irq err", 28'h000_0000, {24'h0, qf, irq, err});
		rreg(4'hf, r);
		chk("unmapped", 28'h000_0000, r);
		rreg(4'ha, r);
		chk("status", 28'h000_0003, r);
		@(posedge clk) oen_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk("drivers on", 28'h000_0000, 28'(bus_oe_n));
		@(posedge clk) oen_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("drivers off", 28'h000_0001, 28'(bus_oe_n));
		$display("test reset and drivers done");
		off = 18'($random(seed)) & 18'h0_03ff;
		wreg(4'h3, 28'h000_001f);
		wreg(4'h5, 28'(off));
		wreg(4'h4, MODE);
		repeat (4) begin
			shot(1'b0);
			waitq;
			pair;
		end
		chk("drained", 28'h000_0003, 28'(qe));
		wreg(4'h6, 28'h000_0003);
		for (k = 0; k < 3; k++) begin
			shot(1'b0);
			da[k] = d0;
			db[k] = d1;
			repeat (10) @(posedge clk);
			chk("fill", k == 2 ? 28'h000_0003 : 28'h0, 28'(qf));
		end
		for (k = 0; k < 3; k++) begin
			rreg(4'h8, r);
			chk("block 0", expv(da[k]), r);
			rreg(4'h9, r);
			chk("block 1", expv(db[k]), r);
		end
		wreg(4'h6, 28'h000_0000);
		$display("test results and fill done");
		shot(1'b0);
		repeat (10) @(posedge clk);
		wreg(4'h4, MODE | PART);
		repeat (5) @(posedge clk);
		pair;
		shot(1'b0);
		repeat (10) @(posedge clk);
		wreg(4'h4, MODE | FULL);
		repeat (5) @(posedge clk);
		chk("full reset", 28'h000_0003, 28'(qe));
		wreg(4'h5, 28'(off) | 28'h020_0000);
		shot(1'b0);
		repeat (10) @(posedge clk);
		pulse_trig;
		chk("pin reset", 28'h000_0003, 28'(qe));
		wreg(4'h5, 28'(off));
		shot(1'b0);
		waitq;
		pair;
		$display("test resets done");
		shot(1'b0);
		waitq;
		wreg(4'he, 28'h000_0010);
		rreg(4'h8, r);
		rreg(4'h8, r2);
		chk("half words 0", expv(d0), {r2[11:0], r[15:0]});
		rreg(4'h9, r);
		rreg(4'h9, r2);
		chk("half words 1", expv(d1), {r2[11:0], r[15:0]});
		wreg(4'he, 28'h000_0000);
		wreg(4'he, 28'h000_0000);
		$display("test narrow bus done");
		for (k = 0; k < 2; k++) begin
			wreg(4'h4, MODE | QUIET);
			shot(1'b0);
			repeat (60) @(posedge clk);
			chk("held", 28'h000_0003, 28'(qe));
			if (k == 1)
				pulse_trig;
			else
				wreg(4'h4, MODE | QUIET | PTRIG);
			waitq;
			pair;
		end
		wreg(4'h4, MODE);
		wreg(4'h3, 28'h100_001f);
		shot(1'b0);
		repeat (20) @(posedge clk);
		chk("core ignored", 28'h000_0003, 28'(qe));
		shot(1'b1);
		waitq;
		pair;
		wreg(4'h3, 28'h000_001f);
		$display("test quiet and test inputs done");
		wreg(4'hb, 28'h7ff_0000);
		wreg(4'hc, 28'h3ff_e000);
		for (k = 0; k < 10; k++) begin
			@(posedge clk);
			hqf <= k < 8 ? 8'h01 << k : 8'h00;
			pll <= k == 8;
			hqe <= k == 9;
			@(posedge clk);
			#1 chk("irq err", {26'h0, 1'b1, k != 9}, {26'h0, irq, err});
		end
		@(posedge clk) pll <= 1'b1;
		wreg(4'hb, 28'h000_0000);
		wreg(4'hc, 28'h000_0000);
		@(posedge clk);
		#1 chk("masked", 28'h000_0000, {26'h0, irq, err});
		@(posedge clk);
		pll <= 1'b0;
		hqe <= 1'b0;
		$display("test flags done");
		wreg(4'hc, 28'h200_0000);
		wreg(4'h7, 28'h001_4000);
		for (k = 0; k < 2; k++) begin
			wreg(4'h4, MODE | (k == 1 ? 28'h000_0400 : 28'h000_0100));
			#1 chk("timer idle", 28'h000_0000, 28'(irq));
			shot(1'b0);
			repeat (30) @(posedge clk);
			chk("timer expired", 28'h000_0001, 28'(irq));
			wreg(4'h4, MODE | PART);
			repeat (3) @(posedge clk);
			#1 chk("timer cleared", 28'h000_0000, 28'(irq));
			pair;
		end
		$display("test timer done");
		summarize;
	end
endmodule // tdcrc_readout_tb
`default_nettype wire
